// [logic/adcw_defs.vh]
// Register map, field positions and timing constants of the converter control block
`ifndef ADCW_DEFS_VH
`define ADCW_DEFS_VH
// Register indices; byte address is four times the index
`define ADCW_IDX_CONTROL_C_REGISTER 8'h0A
`define ADCW_IDX_AVG 8'h0C
`define ADCW_IDX_SAMP 8'h0D
`define ADCW_IDX_WINDOW_LOW_LIMIT 8'h0E
`define ADCW_IDX_WINDOW_HIGH_LIMIT 8'h10
`define ADCW_IDX_GAIN 8'h12
`define ADCW_IDX_OFFS 8'h14
`define ADCW_IDX_TRIG 8'h18
`define ADCW_IDX_BUSY 8'h20
`define ADCW_IDX_RESULT 8'h24
`define ADCW_IDX_STATUS 8'h30
// Writable field masks, reserved bits read zero
`define ADCW_MASK_CONTROL_C_REGISTER 16'h073F
`define ADCW_MASK_AVG 16'h007F
`define ADCW_MASK_SAMP 16'h00BF
`define ADCW_MASK_12 16'h0FFF
// Field positions
`define ADCW_AVG_CNT 3:0
`define ADCW_AVG_ADJ 6:4
`define ADCW_SAMP_LEN 5:0
`define ADCW_SAMP_COMPARATOR_OFFSET_COMP 7
`define ADCW_CONTROL_C_REGISTER_FREERUN 2
`define ADCW_CONTROL_C_REGISTER_CORRECTION_ENABLE 3
`define ADCW_CONTROL_C_REGISTER_RES 5:4
`define ADCW_CONTROL_C_REGISTER_WMODE 10:8
`define ADCW_TRIG_FLUSH 0
`define ADCW_TRIG_START 1
// Busy flag positions
`define ADCW_BUSY_CONTROL_C_REGISTER 3
`define ADCW_BUSY_AVG 4
`define ADCW_BUSY_SAMP 5
`define ADCW_BUSY_WINDOW_LOW_LIMIT 6
`define ADCW_BUSY_WINDOW_HIGH_LIMIT 7
`define ADCW_BUSY_GAIN 8
`define ADCW_BUSY_OFFS 9
`define ADCW_BUSY_TRIG 10
// Limits and timing
`define ADCW_CNT_MAX 4'hA
`define ADCW_COMPARATOR_OFFSET_COMP_TS 7'h04
`define ADCW_CORR_CYC 4'hD
`define ADCW_GAIN_FRAC 11
// Window modes
`define ADCW_WM_ABOVE 3'h1
`define ADCW_WM_BELOW 3'h2
`define ADCW_WM_INSIDE 3'h3
`define ADCW_WM_OUTSIDE 3'h4
// Resolution codes and saturation limits
`define ADCW_RES_12 2'h0
`define ADCW_RES_16 2'h1
`define ADCW_RES_10 2'h2
`define ADCW_MAX_12 24'h000FFF
`define ADCW_MAX_16 24'h00FFFF
`define ADCW_MAX_10 24'h0003FF
`define ADCW_MAX_8 24'h0000FF
`endif

// [logic/adcw_top.v]
// Converter result path, sampling control, window monitor and trigger over Avalon-MM
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "adcw_defs.vh"
module adcw_top (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Avalon-MM slave, byte address
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Analog core
	output reg core_sample,
	output reg core_convert,
	output reg core_flush,
	input wire [11:0] core_data,
	input wire core_data_valid,
	// Result side
	output reg [15:0] result_out,
	output reg result_ready,
	output reg window_match
);
	localparam ST_IDLE = 5'b00001;
	localparam ST_SAMPLE = 5'b00010;
	localparam ST_CONV = 5'b00100;
	localparam ST_CORR = 5'b01000;
	localparam ST_DONE = 5'b10000;
	function [15:0] merge;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] be;
		input [15:0] mask;
		begin
			merge[7:0] = be[0] ? wd[7:0] : old[7:0];
			merge[15:8] = be[1] ? wd[15:8] : old[15:8];
			merge = merge & mask;
		end
	endfunction
	function [23:0] res_max;
		input [1:0] res;
		begin
			case (res)
				`ADCW_RES_12: res_max = `ADCW_MAX_12;
				`ADCW_RES_16: res_max = `ADCW_MAX_12;
				`ADCW_RES_10: res_max = `ADCW_MAX_10;
				default: res_max = `ADCW_MAX_8;
			endcase
		end
	endfunction
	// Bus side shadows
	reg ack_q;
	reg [15:0] control_c_register_q, avg_q, samp_q, window_low_limit_q, window_high_limit_q, gain_q, offs_q;
	// Converter side active copies
	reg [15:0] a_control_c_register_q, a_avg_q, a_samp_q, a_window_low_limit_q, a_window_high_limit_q, a_gain_q, a_offs_q;
	reg [10:0] sync1_q, sync2_q;
	reg start_q;
	reg [4:0] state_q;
	reg [6:0] tcnt_q;
	reg [10:0] scnt_q;
	reg [21:0] acc_q;
	reg [11:0] raw_q;
	wire [7:0] idx = avs_address >> 2;
	wire wr_go = avs_write & ack_q;
	wire rd_go = avs_read & ~ack_q;
	wire [10:0] wr_mask;
	wire [10:0] busy = sync1_q | sync2_q;
	wire flush_wr = wr_go && (idx == `ADCW_IDX_TRIG) && avs_byteenable[0]
		&& avs_writedata[`ADCW_TRIG_FLUSH];
	// One wait state on every access
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_mask = {11{wr_go}} & {
		idx == `ADCW_IDX_TRIG, idx == `ADCW_IDX_OFFS, idx == `ADCW_IDX_GAIN,
		idx == `ADCW_IDX_WINDOW_HIGH_LIMIT, idx == `ADCW_IDX_WINDOW_LOW_LIMIT, idx == `ADCW_IDX_SAMP,
		idx == `ADCW_IDX_AVG, idx == `ADCW_IDX_CONTROL_C_REGISTER, 3'b000};
	always @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ack_q <= 1'b0;
			avs_readdata <= 32'h00000000;
			control_c_register_q <= 16'h0000;
			avg_q <= 16'h0000;
			samp_q <= 16'h0000;
			window_low_limit_q <= 16'h0000;
			window_high_limit_q <= 16'h0000;
			gain_q <= 16'h0000;
			offs_q <= 16'h0000;
			sync1_q <= 11'h000;
			sync2_q <= 11'h000;
		end
		else
		begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
			sync1_q <= wr_mask;
			sync2_q <= sync1_q;
			if (rd_go)
			begin
				case (idx)
					`ADCW_IDX_CONTROL_C_REGISTER: avs_readdata <= {16'h0000, control_c_register_q};
					`ADCW_IDX_AVG: avs_readdata <= {16'h0000, avg_q};
					`ADCW_IDX_SAMP: avs_readdata <= {16'h0000, samp_q};
					`ADCW_IDX_WINDOW_LOW_LIMIT: avs_readdata <= {16'h0000, window_low_limit_q};
					`ADCW_IDX_WINDOW_HIGH_LIMIT: avs_readdata <= {16'h0000, window_high_limit_q};
					`ADCW_IDX_GAIN: avs_readdata <= {16'h0000, gain_q};
					`ADCW_IDX_OFFS: avs_readdata <= {16'h0000, offs_q};
					`ADCW_IDX_BUSY: avs_readdata <= {21'h000000, busy};
					`ADCW_IDX_RESULT: avs_readdata <= {16'h0000, result_out};
					`ADCW_IDX_STATUS: avs_readdata <= {27'h0000000, state_q == ST_IDLE,
						result_ready, window_match, state_q != ST_IDLE, start_q};
					default: avs_readdata <= 32'h00000000;
				endcase
			end
			if (wr_go)
			begin
				case (idx)
					`ADCW_IDX_CONTROL_C_REGISTER: control_c_register_q <= merge(control_c_register_q, avs_writedata, avs_byteenable,
						`ADCW_MASK_CONTROL_C_REGISTER);
					`ADCW_IDX_AVG: avg_q <= merge(avg_q, avs_writedata, avs_byteenable,
						`ADCW_MASK_AVG);
					`ADCW_IDX_SAMP: samp_q <= merge(samp_q, avs_writedata, avs_byteenable,
						`ADCW_MASK_SAMP);
					`ADCW_IDX_WINDOW_LOW_LIMIT: window_low_limit_q <= merge(window_low_limit_q, avs_writedata, avs_byteenable,
						16'hFFFF);
					`ADCW_IDX_WINDOW_HIGH_LIMIT: window_high_limit_q <= merge(window_high_limit_q, avs_writedata, avs_byteenable,
						16'hFFFF);
					`ADCW_IDX_GAIN: gain_q <= merge(gain_q, avs_writedata, avs_byteenable,
						`ADCW_MASK_12);
					`ADCW_IDX_OFFS: offs_q <= merge(offs_q, avs_writedata, avs_byteenable,
						`ADCW_MASK_12);
					default: ;
				endcase
			end
		end
	end
	// Active copies load when the crossing for that register ends
	always @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			a_control_c_register_q <= 16'h0000;
			a_avg_q <= 16'h0000;
			a_samp_q <= 16'h0000;
			a_window_low_limit_q <= 16'h0000;
			a_window_high_limit_q <= 16'h0000;
			a_gain_q <= 16'h0000;
			a_offs_q <= 16'h0000;
		end
		else
		begin
			if (sync2_q[`ADCW_BUSY_CONTROL_C_REGISTER]) a_control_c_register_q <= control_c_register_q;
			if (sync2_q[`ADCW_BUSY_AVG]) a_avg_q <= avg_q;
			if (sync2_q[`ADCW_BUSY_SAMP]) a_samp_q <= samp_q;
			if (sync2_q[`ADCW_BUSY_WINDOW_LOW_LIMIT]) a_window_low_limit_q <= window_low_limit_q;
			if (sync2_q[`ADCW_BUSY_WINDOW_HIGH_LIMIT]) a_window_high_limit_q <= window_high_limit_q;
			if (sync2_q[`ADCW_BUSY_GAIN]) a_gain_q <= gain_q;
			if (sync2_q[`ADCW_BUSY_OFFS]) a_offs_q <= offs_q;
		end
	end
	wire [6:0] ts_cyc = a_samp_q[`ADCW_SAMP_COMPARATOR_OFFSET_COMP] ? `ADCW_COMPARATOR_OFFSET_COMP_TS
		: ({1'b0, a_samp_q[`ADCW_SAMP_LEN]} + 7'h01);
	wire [3:0] cnt_code = (a_avg_q[`ADCW_AVG_CNT] > `ADCW_CNT_MAX) ? `ADCW_CNT_MAX
		: a_avg_q[`ADCW_AVG_CNT];
	wire [10:0] n_samples = 11'h001 << cnt_code;
	wire corr_en = a_control_c_register_q[`ADCW_CONTROL_C_REGISTER_CORRECTION_ENABLE];
	wire [23:0] sat_max = res_max(a_control_c_register_q[`ADCW_CONTROL_C_REGISTER_RES]);
	wire signed [13:0] off_sub = $signed({2'b00, raw_q}) - $signed({{2{a_offs_q[11]}},
		a_offs_q[11:0]});
	wire signed [27:0] gain_prod = off_sub * $signed({2'b00, a_gain_q[11:0]});
	wire signed [27:0] gain_shr = gain_prod >>> `ADCW_GAIN_FRAC;
	wire [11:0] corr_val = gain_shr[27] ? 12'h000
		: ({4'h0, gain_shr[23:0]} > {4'h0, sat_max}) ? sat_max[11:0] : gain_shr[11:0];
	wire [11:0] sample_val = corr_en ? corr_val : raw_q;
	wire [21:0] acc_next = acc_q + {10'h000, sample_val};
	wire [21:0] acc_div = acc_next >> a_avg_q[`ADCW_AVG_ADJ];
	wire start_wr = wr_go && (idx == `ADCW_IDX_TRIG) && avs_byteenable[0]
		&& avs_writedata[`ADCW_TRIG_START];
	wire in_conv = (state_q != ST_IDLE) && (state_q != ST_DONE);
	always @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= ST_IDLE;
			start_q <= 1'b0;
			tcnt_q <= 7'h00;
			scnt_q <= 11'h000;
			acc_q <= 22'h000000;
			raw_q <= 12'h000;
			core_sample <= 1'b0;
			core_convert <= 1'b0;
			core_flush <= 1'b0;
			result_out <= 16'h0000;
			result_ready <= 1'b0;
		end
		else
		begin
			core_convert <= 1'b0;
			core_flush <= 1'b0;
			// set while set is a no-op
			if (start_wr)
				start_q <= 1'b1;
			if (flush_wr)
			begin
				core_flush <= 1'b1;
				core_sample <= 1'b0;
				state_q <= ST_IDLE;
				scnt_q <= 11'h000;
				acc_q <= 22'h000000;
				if (in_conv)
					start_q <= 1'b1;
			end
			else
			begin
				case (state_q)
					ST_IDLE:
					begin
						if (start_q || a_control_c_register_q[`ADCW_CONTROL_C_REGISTER_FREERUN])
						begin
							start_q <= start_wr;
							state_q <= ST_SAMPLE;
							tcnt_q <= ts_cyc;
							core_sample <= 1'b1;
						end
					end
					ST_SAMPLE:
					begin
						tcnt_q <= tcnt_q - 7'h01;
						if (tcnt_q == 7'h01)
						begin
							core_sample <= 1'b0;
							core_convert <= 1'b1;
							state_q <= ST_CONV;
						end
					end
					ST_CONV:
					begin
						if (core_data_valid)
						begin
							raw_q <= core_data;
							tcnt_q <= {3'b000, `ADCW_CORR_CYC};
							state_q <= corr_en ? ST_CORR : ST_DONE;
						end
					end
					ST_CORR:
					begin
						tcnt_q <= tcnt_q - 7'h01;
						if (tcnt_q == 7'h01)
							state_q <= ST_DONE;
					end
					default:
					begin
						if (scnt_q + 11'h001 == n_samples)
						begin
							result_out <= acc_div[15:0];
							result_ready <= 1'b1;
							acc_q <= 22'h000000;
							scnt_q <= 11'h000;
							state_q <= ST_IDLE;
						end
						else
						begin
							acc_q <= acc_next;
							scnt_q <= scnt_q + 11'h001;
							state_q <= ST_SAMPLE;
							tcnt_q <= ts_cyc;
							core_sample <= 1'b1;
						end
					end
				endcase
			end
		end
	end
	wire above_lt = result_out > a_window_low_limit_q;
	wire below_ut = result_out < a_window_high_limit_q;
	reg win_hit;
	always @*
	begin
		case (a_control_c_register_q[`ADCW_CONTROL_C_REGISTER_WMODE])
			`ADCW_WM_ABOVE: win_hit = above_lt;
			`ADCW_WM_BELOW: win_hit = below_ut;
			`ADCW_WM_INSIDE: win_hit = above_lt & below_ut;
			`ADCW_WM_OUTSIDE: win_hit = (result_out < a_window_low_limit_q) | (result_out > a_window_high_limit_q);
			default: win_hit = 1'b0;
		endcase
	end
	always @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			window_match <= 1'b0;
		else
			window_match <= result_ready & win_hit;
	end
endmodule // adcw_top
`default_nettype wire

// [test/adcw_checker.sv]
// Port-level checks on the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcw_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	// Core and result
	input wire logic core_sample,
	input wire logic core_convert,
	input wire logic core_flush,
	input wire logic [15:0] result_out,
	input wire logic result_ready,
	input wire logic window_match
);
	logic take_w;
	logic [7:0] samp_q;
	logic [6:0] run_q;
	assign take_w = avs_write && !avs_waitrequest && avs_byteenable[0];
	always @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			samp_q <= 8'h00;
			run_q <= 7'h00;
		end
		else
		begin
			// No sync lag kept: settings only change between conversions
			if (take_w && avs_address[7:2] == 6'h0D)
				samp_q <= avs_writedata[7:0];
			run_q <= core_sample ? run_q + 7'h01 : 7'h00;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_flush_req;
		take_w && avs_address[7:2] == 6'h18 && avs_writedata[0];
	endsequence
	sequence s_sample_end;
		$fell(core_sample) && !core_flush;
	endsequence
	property p_wait_first;
		$rose(avs_read || avs_write) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait state on new access");
	property p_flush_pulse;
		s_flush_req |=> core_flush ##1 !core_flush;
	endproperty
	a_flush_pulse: assert property (p_flush_pulse) else $error("flush pulse wrong");
	property p_flush_abort;
		s_flush_req |=> !core_sample && !core_convert;
	endproperty
	a_flush_abort: assert property (p_flush_abort) else $error("flush did not abort");
	property p_ts_comp;
		s_sample_end and samp_q[7] |-> run_q == 7'h04;
	endproperty
	a_ts_comp: assert property (p_ts_comp) else $error("compensated Ts not 4");
	property p_ts_len;
		s_sample_end and !samp_q[7] |-> run_q == {1'b0, samp_q[5:0]} + 7'h01;
	endproperty
	a_ts_len: assert property (p_ts_len) else $error("Ts not length plus one");
	property p_conv_follow;
		s_sample_end |-> core_convert ##1 !core_convert;
	endproperty
	a_conv_follow: assert property (p_conv_follow) else $error("convert pulse missing");
	property p_ready_sticky;
		result_ready |=> result_ready;
	endproperty
	a_ready_sticky: assert property (p_ready_sticky) else $error("ready dropped");
	property p_result_store;
		!$stable(result_out) |-> result_ready;
	endproperty
	a_result_store: assert property (p_result_store) else $error("result without ready");
	property p_win_ready;
		window_match |-> $past(result_ready);
	endproperty
	a_win_ready: assert property (p_win_ready) else $error("match before result");
endmodule // adcw_checker
bind adcw_top adcw_checker chk_u (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_waitrequest, .core_sample, .core_convert,
	.core_flush, .result_out, .result_ready, .window_match);
`default_nettype wire

// [test/adcw_core_model.sv]
// Behavioural analog core answering each convert pulse
`timescale 1ns/10ps
`default_nettype none
module adcw_core_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Core handshake
	input wire logic core_convert,
	input wire logic core_flush,
	input wire logic [11:0] conv_value,
	input wire logic [2:0] conv_delay,
	output logic [11:0] core_data,
	output logic core_data_valid
);
	logic [2:0] cnt_q;
	always @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q <= 3'h0;
			core_data_valid <= 1'b0;
			core_data <= 12'hA5A;
		end
		else
		begin
			// Flush drops the conversion in flight
			cnt_q <= core_flush ? 3'h0 : core_convert ? conv_delay : cnt_q - {2'h0, cnt_q != 3'h0};
			core_data_valid <= cnt_q == 3'h1 && !core_flush;
			// Data lines are not held outside the valid pulse
			core_data <= cnt_q == 3'h1 ? conv_value : ~core_data;
		end
	end
endmodule // adcw_core_model
`default_nettype wire

// [test/adcw_top_tb.sv]
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcw_top_tb;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h3;
	logic [31:0] avs_readdata, rdata;
	logic avs_waitrequest, core_sample, core_convert, core_flush, core_data_valid;
	logic result_ready, window_match;
	logic [11:0] core_data;
	logic [11:0] conv_value = 12'h000;
	logic [2:0] conv_delay = 3'h1;
	logic [15:0] result_out;
	integer bad_count = 0;
	integer total_checks = 0;
	integer lat_n = 0;
	always #2.5 ref_clk = ~ref_clk;
	adcw_top dut_u (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .core_sample, .core_convert,
		.core_flush, .core_data, .core_data_valid, .result_out, .result_ready, .window_match);
	adcw_core_model core_u (.ref_clk, .sys_rst, .core_convert, .core_flush, .conv_value,
		.conv_delay, .core_data, .core_data_valid);
	task automatic finish_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, bad_count);
			if (bad_count == 0 && total_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task automatic give_up;
		begin
			bad_count++;
			$display("BAD wait expected done seen timeout");
			finish_test;
		end
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		begin
			total_checks++;
			if (got !== exp)
			begin
				bad_count++;
				$display("BAD %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task automatic bus(input logic rd, input logic [7:0] idx, input logic [15:0] wd);
		integer n;
		begin
			n = 0;
			@(posedge ref_clk);
			avs_address <= {idx[5:0], 2'b00};
			avs_read <= rd;
			avs_write <= !rd;
			avs_writedata <= {16'h0000, wd};
			// Waitrequest and read data judged as they stand at each rising edge
			@(posedge ref_clk);
			while (avs_waitrequest !== 1'b0 && n < 50)
			begin
				@(posedge ref_clk);
				n = n + 1;
			end
			if (n >= 50)
				give_up;
			rdata = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task automatic t_regs;
		logic [7:0] idx [6] = '{8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h12, 8'h14};
		begin
			foreach (idx[i])
			begin
				bus(1'b1, idx[i], 16'h0000);
				chk("reset value", 32'h0, rdata);
			end
			bus(1'b0, 8'h0D, 16'hFFFF);
			bus(1'b1, 8'h0D, 16'h0000);
			chk("timing mask", 32'h00BF, rdata);
			bus(1'b0, 8'h12, 16'hFFFF);
			bus(1'b1, 8'h12, 16'h0000);
			chk("gain mask", 32'h0FFF, rdata);
			bus(1'b1, 8'h3F, 16'h0000);
			chk("unmapped", 32'h0, rdata);
			bus(1'b1, 8'h18, 16'h0000);
			chk("trigger read", 32'h0, rdata);
			$display("registers done");
		end
	endtask
	task automatic t_busy;
		begin
			bus(1'b0, 8'h14, 16'hFFFF);
			bus(1'b1, 8'h20, 16'h0000);
			chk("busy set", 32'h0200, rdata);
			repeat (6) @(posedge ref_clk);
			bus(1'b1, 8'h20, 16'h0000);
			chk("busy clear", 32'h0, rdata);
			$display("busy done");
		end
	endtask
	task automatic wait_res(input logic [15:0] prev, input logic [15:0] exp);
		integer n;
		begin
			n = 0;
			lat_n = 0;
			while (result_out === prev && n < 3000)
			begin
				@(negedge ref_clk);
				n = n + 1;
				// Cycles from the last core answer to the stored result
				lat_n = (core_data_valid === 1'b1) ? 0 : lat_n + 1;
			end
			if (n >= 3000)
				give_up;
			@(posedge ref_clk);
			chk("result", exp, result_out);
		end
	endtask
	task automatic t_conv(input logic [7:0] samp, input logic [7:0] avg, input logic [11:0] val,
		input logic [15:0] exp);
		begin
			conv_value <= val;
			bus(1'b0, 8'h0D, {8'h00, samp});
			bus(1'b0, 8'h0C, {8'h00, avg});
			repeat (4) @(posedge ref_clk);
			bus(1'b0, 8'h18, 16'h0002);
			wait_res(result_out, exp);
			$display("conversion done");
		end
	endtask
	task automatic t_corr(input logic [11:0] off, input logic [15:0] exp);
		begin
			bus(1'b0, 8'h12, 16'h0600);
			bus(1'b0, 8'h14, {4'h0, off});
			bus(1'b0, 8'h0A, 16'h0008);
			t_conv(8'h00, 8'h00, 12'h100, exp);
			chk("corr latency", 32'd15, lat_n);
		end
	endtask
	task automatic t_wide;
		begin
			bus(1'b0, 8'h0A, 16'h0010);
			t_conv(8'h00, 8'h04, 12'h100, 16'h1000);
			chk("plain latency", 32'd2, lat_n);
		end
	endtask
	task automatic t_win;
		logic [4:0] exp_w = 5'b10100;
		begin
			bus(1'b0, 8'h0E, 16'h00D0);
			bus(1'b0, 8'h10, 16'h0100);
			for (int m = 0; m < 5; m++)
			begin
				bus(1'b0, 8'h0A, {5'h00, m[2:0], 8'h08});
				repeat (8) @(posedge ref_clk);
				chk("window", {31'h0, exp_w[m]}, {31'h0, window_match});
			end
			$display("window done");
		end
	endtask
	task automatic t_flush;
		integer n;
		begin
			conv_value <= 12'h200;
			bus(1'b0, 8'h0D, 16'h003F);
			repeat (4) @(posedge ref_clk);
			bus(1'b0, 8'h18, 16'h0002);
			repeat (10) @(posedge ref_clk);
			bus(1'b0, 8'h18, 16'h0001);
			@(negedge ref_clk);
			chk("abort", 32'h0, {31'h0, core_sample});
			n = 0;
			while (core_sample !== 1'b1 && n < 20)
			begin
				@(negedge ref_clk);
				n = n + 1;
			end
			chk("restart", 32'h1, {31'h0, core_sample});
			wait_res(result_out, 16'h018C);
			$display("flush done");
		end
	endtask
	task automatic t_zero;
		integer hits;
		begin
			hits = 0;
			bus(1'b0, 8'h18, 16'h0000);
			repeat (30)
			begin
				@(negedge ref_clk);
				hits = hits + (core_sample === 1'b1);
			end
			chk("zero start", 32'h0, hits);
			$display("zero write done");
		end
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_regs;
		t_busy;
		t_conv(8'h02, 8'h12, 12'h100, 16'h0200);
		conv_delay <= 3'h7;
		t_conv(8'h85, 8'h00, 12'h123, 16'h0123);
		conv_delay <= 3'h1;
		t_wide;
		t_corr(12'h010, 16'h00B4);
		t_corr(12'hFF0, 16'h00CC);
		t_win;
		t_flush;
		t_zero;
		finish_test;
	end
endmodule // adcw_top_tb
`default_nettype wire
